// [include/tmr16_pkg.sv]
/*
 * constants of the 16-bit free-running timer core: byte register map,
 * field positions, reset values, clock select codes and read-sequence states.
 * assumes an 8-bit register port with 4-bit byte addresses.
 */
package tmr16_pkg;
    // register map (byte addresses)
    localparam logic [3:0] A_CTRL1 = 4'h0;
    localparam logic [3:0] A_CTRL2 = 4'h1;
    localparam logic [3:0] A_STAT = 4'h2;
    localparam logic [3:0] A_CHR = 4'h3;
    localparam logic [3:0] A_CLR = 4'h4;
    localparam logic [3:0] A_ALT_COUNT_HIGH_BYTE = 4'h5;
    localparam logic [3:0] A_ALT_COUNT_LOW_BYTE = 4'h6;
    localparam logic [3:0] A_EVT = 4'h7;
    localparam logic [3:0] A_EMSK = 4'h8;
    // field positions
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int CC_LSB = 2;
    localparam int EXT_EDGE_SELECT_BIT = 1;
    localparam int TOF_BIT = 5;
    localparam int EV_OVF = 0;
    localparam int EV_EXT = 1;
    localparam int EV_W = 2;
    // reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [1:0] EV_RST = 2'h0;
    localparam logic [15:0] CNT_RST = 16'hFFFC;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // clock select codes and prescaler masks (divide by mask + 1)
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV4 = 2'h1;
    localparam logic [1:0] CS_DIV8 = 2'h2;
    localparam logic [1:0] CS_EXT = 2'h3;
    localparam logic [2:0] PM_DIV2 = 3'h1;
    localparam logic [2:0] PM_DIV4 = 3'h3;
    localparam logic [2:0] PM_DIV8 = 3'h7;
    // 16-bit read sequence states
    typedef enum logic [1:0] {
        RS_IDLE = 2'b01,
        RS_HELD = 2'b10
    } tmr16_rseq_t;
endpackage

// [include/tmr16_tick_if.sv]
/*
 * count-enable carrier between the tick sources and the counter core.
 * assumes one clock; the tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
interface tmr16_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire

// [src/tmr16_presc.sv]
/*
 * cpu clock prescaler: one tick every 2, 4 or 8 clocks.
 * assumes i_run low freezes the division state.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr16_presc
    import tmr16_pkg::*;
#(
    parameter int PW = 3
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    tmr16_tick_if.src tk
);
    if (PW < 3) begin : g_chk
        $error("prescaler needs at least 3 bits");
    end

    logic [PW-1:0] div_ff;
    logic [PW-1:0] nxt_div;
    logic [2:0] msk;

    always_comb begin
        case (i_sel)
            CS_DIV2: msk = PM_DIV2;
            CS_DIV4: msk = PM_DIV4;
            default: msk = PM_DIV8;
        endcase
        nxt_div = i_run ? div_ff + {{(PW-1){1'b0}}, 1'b1} : div_ff;
        tk.tick = i_run && ((div_ff[2:0] & msk) == msk);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule
`default_nettype wire

// [src/tmr16_edge.sv]
/*
 * external clock pin: two-flop synchroniser and selected-edge detector.
 * assumes the pin changes slower than a quarter of i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr16_edge (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_pin,
    input wire logic i_rise,
    tmr16_tick_if.src tk
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // s1 is read only by s2
    always_comb begin
        tk.tick = i_rise ? (s2_ff && !s3_ff) : (!s2_ff && s3_ff);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end else begin
            s1_ff <= i_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
endmodule
`default_nettype wire

// [src/tmr16_top.sv]
/*
 * 16-bit free-running timer core: prescaled or external count clock,
 * main and alternate count views with buffered high-then-low read,
 * overflow flag with two-step clear, event status and interrupt.
 * assumes an 8-bit register port whose read data follow one cycle later,
 * a cpu interrupt mask input and a halt level from the power controller.
 */
// Our own choices: the address map and the plain strobed port.
// How it works
// - count clock is cpu clock over 2, 4, 8 or external pin
// - both clock-select bits set choose the external clock pin
// - edge select bit picks rising or falling external edge
// - counter changes only on the block clock, even for external edges
// - 16-bit up-counter, read as main and alternate views, byte split
// - counter loads FFFC at reset, never any other reload value
// - writing either low count byte forces FFFC
// - high byte read latches low byte, held until low byte read
// - low byte read outside a sequence returns the live low byte
// - rollover FFFF to 0000 sets the overflow flag
// - interrupt only with global mask clear and either overflow enable set or an unmasked event pending
// - flag clears after status read with flag set, then main low access
// - alternate low byte access never touches the overflow flag
// - wait mode changes nothing, counting goes on
// - halt freezes counter; interrupt wake resumes, reset wake reloads
// - an unbonded timer input reads as constant one
`timescale 1ns/1ps
`default_nettype none
module tmr16_top
    import tmr16_pkg::*;
#(
    parameter bit EXT_PIN_BONDED = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_clock_pin,
    input wire logic i_halt,
    input wire logic i_glob_mask,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] ctrl1_ff;
    logic [7:0] nxt_ctrl1;
    logic [7:0] ctrl2_ff;
    logic [7:0] nxt_ctrl2;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic tof_ff;
    logic nxt_tof;
    logic arm_ff;
    logic nxt_arm;
    tmr16_rseq_t rs_ff;
    tmr16_rseq_t nxt_rs;
    logic [7:0] lo_buf_ff;
    logic [7:0] nxt_lo_buf;
    logic [EV_W-1:0] evt_ff;
    logic [EV_W-1:0] nxt_evt;
    logic [EV_W-1:0] emsk_ff;
    logic [EV_W-1:0] nxt_emsk;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic [1:0] clock_select_bits;
    logic ext_edge_select;
    logic overflow_irq_enable;
    logic sel_ext;
    logic ext_clock_pin;
    logic ext_tick;
    logic tick;
    logic ovf_evt;
    logic wr_low;
    logic acc_clr;
    logic rd_hi;
    logic rd_lo;
    logic rd_sr;
    logic rd_evt;

    tmr16_tick_if pre_if ();
    tmr16_tick_if ext_if ();

    ////////////////////////////////////////////////////////////////////////
    // tick sources

    // a missing pin must look idle high, not float into false edges
    assign ext_clock_pin = EXT_PIN_BONDED ? i_ext_clock_pin : 1'b1;

    // halt stops the prescaler so the division phase is kept too
    tmr16_presc #(
        .PW(3)
    ) u_presc (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_run(!i_halt),
        .i_sel(clock_select_bits),
        .tk(pre_if.src)
    );

    tmr16_edge u_edge (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_pin(ext_clock_pin),
        .i_rise(ext_edge_select),
        .tk(ext_if.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode and counter

    always_comb begin
        clock_select_bits = ctrl2_ff[CC_LSB +: 2];
        ext_edge_select = ctrl2_ff[EXT_EDGE_SELECT_BIT];
        overflow_irq_enable = ctrl1_ff[OVERFLOW_IRQ_ENABLE_BIT];
        sel_ext = (clock_select_bits == CS_EXT);
        ext_tick = ext_if.tick && !i_halt;
        tick = sel_ext ? ext_tick : pre_if.tick;
        wr_low = i_wr && ((i_addr == A_CLR) || (i_addr == A_ALT_COUNT_LOW_BYTE));
        acc_clr = (i_wr || i_rd) && (i_addr == A_CLR);
        rd_hi = i_rd && ((i_addr == A_CHR) || (i_addr == A_ALT_COUNT_HIGH_BYTE));
        rd_lo = i_rd && ((i_addr == A_CLR) || (i_addr == A_ALT_COUNT_LOW_BYTE));
        rd_sr = i_rd && (i_addr == A_STAT);
        rd_evt = i_rd && (i_addr == A_EVT);
        ovf_evt = tick && (cnt_ff == CNT_MAX) && !wr_low;
        // counts on every enabled tick, wait or not; the low write wins
        if (wr_low) begin
            nxt_cnt = CNT_RST;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end else begin
            nxt_cnt = cnt_ff;
        end
        nxt_ctrl1 = (i_wr && (i_addr == A_CTRL1)) ? i_wdata : ctrl1_ff;
        nxt_ctrl2 = (i_wr && (i_addr == A_CTRL2)) ? i_wdata : ctrl2_ff;
        nxt_emsk = (i_wr && (i_addr == A_EMSK)) ? i_wdata[EV_W-1:0] : emsk_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flag, its clear arming, event status

    always_comb begin
        // a rollover in the clearing cycle keeps the flag set
        if (ovf_evt) begin
            nxt_tof = 1'b1;
        end else if (arm_ff && acc_clr) begin
            nxt_tof = 1'b0;
        end else begin
            nxt_tof = tof_ff;
        end
        if (rd_sr && tof_ff) begin
            nxt_arm = 1'b1;
        end else if (acc_clr) begin
            nxt_arm = 1'b0;
        end else begin
            nxt_arm = arm_ff;
        end
        nxt_evt = rd_evt ? EV_RST : evt_ff;
        nxt_evt[EV_OVF] = nxt_evt[EV_OVF] | ovf_evt;
        nxt_evt[EV_EXT] = nxt_evt[EV_EXT] | (ext_tick && sel_ext);
    end

    ////////////////////////////////////////////////////////////////////////
    // buffered 16-bit read sequence

    always_comb begin
        nxt_rs = rs_ff;
        nxt_lo_buf = lo_buf_ff;
        case (rs_ff)
            RS_IDLE: begin
                if (rd_hi) begin
                    nxt_lo_buf = cnt_ff[7:0];
                    nxt_rs = RS_HELD;
                end
            end
            RS_HELD: begin
                // repeated high reads leave the buffer alone
                if (rd_lo) begin
                    nxt_rs = RS_IDLE;
                end
            end
            default: begin
                nxt_rs = RS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe, zero otherwise

    always_comb begin
        nxt_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                A_CTRL1: nxt_rdata = ctrl1_ff;
                A_CTRL2: nxt_rdata = ctrl2_ff;
                A_STAT: nxt_rdata[TOF_BIT] = tof_ff;
                A_CHR, A_ALT_COUNT_HIGH_BYTE: nxt_rdata = cnt_ff[15:8];
                A_CLR, A_ALT_COUNT_LOW_BYTE: begin
                    nxt_rdata = (rs_ff == RS_HELD) ? lo_buf_ff : cnt_ff[7:0];
                end
                A_EVT: nxt_rdata[EV_W-1:0] = evt_ff;
                A_EMSK: nxt_rdata[EV_W-1:0] = emsk_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    assign o_rdata = rdata_ff;
    // the cpu mask gates both the overflow request and the event sources
    assign o_irq = !i_glob_mask &&
                   ((tof_ff && overflow_irq_enable) || ((evt_ff & emsk_ff) != '0));

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            ctrl1_ff <= CTRL1_RST;
            ctrl2_ff <= CTRL2_RST;
            cnt_ff <= CNT_RST;
            tof_ff <= 1'b0;
            arm_ff <= 1'b0;
            rs_ff <= RS_IDLE;
            lo_buf_ff <= 8'h00;
            evt_ff <= EV_RST;
            emsk_ff <= EV_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
            ctrl2_ff <= nxt_ctrl2;
            cnt_ff <= nxt_cnt;
            tof_ff <= nxt_tof;
            arm_ff <= nxt_arm;
            rs_ff <= nxt_rs;
            lo_buf_ff <= nxt_lo_buf;
            evt_ff <= nxt_evt;
            emsk_ff <= nxt_emsk;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_hi_then_lo;
        (rd_hi && rs_ff == RS_IDLE) ##1 (!rd_hi && !wr_low)[*1] ##0 rd_lo;
    endsequence

    sequence s_armed_access;
        (rd_sr && tof_ff) ##1 (acc_clr && !ovf_evt);
    endsequence

    low_write_load_a: assert property (wr_low |=> cnt_ff == CNT_RST)
        else $error("low byte write did not load FFFC");

    rollover_flag_a: assert property (
        (tick && cnt_ff == CNT_MAX && !wr_low) |=> (tof_ff && cnt_ff == 16'h0000))
        else $error("rollover did not set overflow flag");

    halt_freeze_a: assert property (
        (i_halt && !wr_low) |=> $stable(cnt_ff))
        else $error("counter moved during halt");

    ext_only_a: assert property (
        (sel_ext && !ext_if.tick && !wr_low) |=> $stable(cnt_ff))
        else $error("external mode counted without an edge");

    div2_spacing_a: assert property (
        (clock_select_bits == CS_DIV2 && !i_halt && pre_if.tick) |=> !pre_if.tick)
        else $error("divide by two ticked twice in a row");

    coherent_read_a: assert property (
        s_hi_then_lo |=> o_rdata == $past(cnt_ff[7:0], 2))
        else $error("low byte not taken from the high byte read");

    buffer_hold_a: assert property (
        (rs_ff == RS_HELD && !rd_lo) |=> (rs_ff == RS_HELD && $stable(lo_buf_ff)))
        else $error("buffered low byte changed before low read");

    two_step_clear_a: assert property (s_armed_access |=> !tof_ff)
        else $error("two-step clear did not clear the flag");

    unarmed_keep_a: assert property ((tof_ff && !arm_ff) |=> tof_ff)
        else $error("flag cleared without status read");

    alt_no_clear_a: assert property (
        (tof_ff && (i_rd || i_wr) && i_addr == A_ALT_COUNT_LOW_BYTE) |=> tof_ff)
        else $error("alternate low access cleared the flag");

    irq_gate_a: assert property (
        (tof_ff && overflow_irq_enable && !i_glob_mask) |-> o_irq)
        else $error("pending overflow request not raised");

    masked_quiet_a: assert property (i_glob_mask |-> !o_irq)
        else $error("interrupt raised while globally masked");

    irq_off_a: assert property (
        (!overflow_irq_enable && (evt_ff & emsk_ff) == '0) |-> !o_irq)
        else $error("interrupt raised with every source disabled");

    ext_single_a: assert property (
        ext_if.tick |=> !ext_if.tick)
        else $error("one external edge gave two count enables");

    ext_count_a: assert property (
        (sel_ext && ext_tick && !wr_low) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("selected external edge did not advance the counter");

    presc_count_a: assert property (
        (!sel_ext && pre_if.tick && !wr_low) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("prescaler tick did not advance the counter");

    halt_no_tick_a: assert property (
        i_halt |-> !tick)
        else $error("count enable seen during halt");

    hi_byte_read_a: assert property (
        rd_hi |=> o_rdata == $past(cnt_ff[15:8]))
        else $error("high byte read returned a wrong value");

    live_low_read_a: assert property (
        (rd_lo && rs_ff == RS_IDLE) |=> o_rdata == $past(cnt_ff[7:0]))
        else $error("low byte read outside a sequence was not live");

    latch_capture_a: assert property (
        (rd_hi && rs_ff == RS_IDLE) |=> (rs_ff == RS_HELD && lo_buf_ff == $past(cnt_ff[7:0])))
        else $error("high byte read did not latch the low byte");

    rdata_idle_a: assert property (
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero without a read");

    status_arm_a: assert property (
        (rd_sr && tof_ff) |=> arm_ff)
        else $error("status read with flag set did not arm the clear");

    ovf_event_a: assert property (
        ovf_evt |=> evt_ff[EV_OVF])
        else $error("rollover did not set the overflow event bit");
endmodule
`default_nettype wire

// [tb/tmr16_ext_src.sv]
/*
 * external count clock source driving the timer clock pin.
 * assumes the bench calls toggle from its own clocked sequence.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr16_ext_src (
    input wire logic i_mclk,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // six clocks per level keeps the source well under a quarter of the cpu clock
    task automatic toggle(input int n);
        for (int k = 0; k < n; k++) begin
            repeat (6) @(posedge i_mclk);
            o_pin <= ~o_pin;
        end
    endtask
endmodule
`default_nettype wire

// [tb/tmr16_tb.sv]
/*
 * self-checking bench for the 16-bit timer core.
 * assumes the map and codes of tmr16_pkg and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tmr16_tb
    import tmr16_pkg::*;
;
    typedef struct packed {
        logic [1:0] cs;
        logic rise;
        logic [7:0] n;
        logic [15:0] cnt;
    } tmr16_row_t;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_halt = 1'b1;
    logic i_glob_mask = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic o_irq;
    logic ext_pin;
    logic [7:0] rb;
    logic [15:0] word;
    int n_mismatch = 0;
    int n_tests = 0;
    // internal rows run a whole number of prescaler periods, so the phase does not matter
    tmr16_row_t rows [5] = '{
        '{CS_DIV2, 1'b0, 8'h10, 16'h0004},
        '{CS_DIV4, 1'b0, 8'h20, 16'h0004},
        '{CS_DIV8, 1'b0, 8'h40, 16'h0004},
        '{CS_EXT, 1'b1, 8'h03, 16'hFFFE},
        '{CS_EXT, 1'b0, 8'h02, 16'hFFFD}};

    always #5 i_mclk = ~i_mclk;

    tmr16_top dut (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_ext_clock_pin(ext_pin),
        .i_halt(i_halt),
        .i_glob_mask(i_glob_mask),
        .o_irq(o_irq)
    );
    tmr16_ext_src src (
        .i_mclk(i_mclk),
        .o_pin(ext_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_test(input string name);
        $display("test %s ended", name);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rb = o_rdata;
    endtask
    // high then low read back to back, as software does it
    task automatic rd16();
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= A_CHR;
        @(posedge i_mclk);
        i_addr <= A_CLR;
        #1 word[15:8] = o_rdata;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 word[7:0] = o_rdata;
    endtask
    task automatic irq_is(input logic exp);
        #1 check("irq", 16'(o_irq), 16'(exp));
    endtask
    // halt low for exactly n edges, or across n pin toggles in external mode
    task automatic run(input int n, input bit ext);
        @(posedge i_mclk);
        i_halt <= 1'b0;
        if (ext) begin
            src.toggle(n);
            repeat (6) @(posedge i_mclk);
        end else begin
            repeat (n) @(posedge i_mclk);
        end
        i_halt <= 1'b1;
    endtask
    task automatic reset_state();
        rd16();
        check("count", word, CNT_RST);
        rd(A_STAT);
        check("status", 16'(rb), 16'h0000);
        rd(A_CTRL2);
        check("ctrl2", 16'(rb), 16'(CTRL2_RST));
        rd(4'hF);
        check("unmapped", 16'(rb), 16'h0000);
        irq_is(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        reset_state();
        end_test("reset");
        foreach (rows[i]) begin
            wr(A_CTRL2, {4'h0, rows[i].cs, rows[i].rise, 1'b0});
            wr(A_CLR, 8'h00);
            run(int'(rows[i].n), rows[i].cs == CS_EXT);
            rd16();
            check("count", word, rows[i].cnt);
            end_test("clock row");
        end
        // flag and interrupt: counter frozen at FFFD
        rd(A_CLR);
        rd(A_STAT);
        check("status", 16'(rb), 16'h0020);
        wr(A_CTRL1, 8'h20);
        irq_is(1'b0);
        @(posedge i_mclk);
        i_glob_mask <= 1'b0;
        @(posedge i_mclk);
        irq_is(1'b1);
        wr(A_CTRL1, 8'h00);
        irq_is(1'b0);
        wr(A_CTRL1, 8'h20);
        irq_is(1'b1);
        rd(A_EVT);
        check("events", 16'(rb), 16'h0003);
        rd(A_EVT);
        check("events", 16'(rb), 16'h0000);
        rd(A_ALT_COUNT_LOW_BYTE);
        rd(A_STAT);
        check("status", 16'(rb), 16'h0020);
        rd(A_CLR);
        rd(A_STAT);
        check("status", 16'(rb), 16'h0000);
        irq_is(1'b0);
        end_test("overflow clear");
        // latched low byte survives counting and a second high read
        wr(A_CTRL1, 8'h00);
        wr(A_EMSK, 8'h01);
        wr(A_CTRL2, 8'h00);
        rd(A_CHR);
        check("high", 16'(rb), 16'h00FF);
        run(8, 1'b0);
        rd(A_CHR);
        check("high", 16'(rb), 16'h0000);
        rd(A_CLR);
        check("low", 16'(rb), 16'h00FD);
        rd(A_CLR);
        check("low", 16'(rb), 16'h0001);
        irq_is(1'b1);
        rd(A_EVT);
        check("events", 16'(rb), 16'h0001);
        irq_is(1'b0);
        end_test("read latch");
        // reset wake from halt reloads, alternate low write forces reload
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        reset_state();
        run(6, 1'b0);
        wr(A_ALT_COUNT_LOW_BYTE, 8'h5A);
        rd16();
        check("count", word, CNT_RST);
        end_test("reset wake");
        test_done();
    end
endmodule
`default_nettype wire
